// *** logic/gpm_map.vh ***
// Purpose: Register offsets, field positions and reset values of the GPIO pad block.
// Assumes: Avalon-MM byte addressing, one register per 32-bit word.
// Notes: Offsets are byte addresses; bits above 7 read as zero, except FUNC bits 10:8.
`ifndef GPM_MAP_VH
`define GPM_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define GPM_ADDR_W 6
`define GPM_OFF_PA_DATA 6'h00
`define GPM_OFF_PB_DATA 6'h04
`define GPM_OFF_PA_DIR 6'h08
`define GPM_OFF_PB_DIR 6'h0c
`define GPM_OFF_PA_PH 6'h10
`define GPM_OFF_PL 6'h14
`define GPM_OFF_PB_PH 6'h18
`define GPM_OFF_PB_OD 6'h1c
`define GPM_OFF_PA_WAKE 6'h20
`define GPM_OFF_PB_WAKE 6'h24
`define GPM_OFF_PWR 6'h28
`define GPM_OFF_IFLAG 6'h2c
`define GPM_OFF_IEN 6'h30
`define GPM_OFF_CORE 6'h34
`define GPM_OFF_EDGE 6'h38
`define GPM_OFF_FUNC 6'h3c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define GPM_PWR_PA5_PH 4
`define GPM_IFLAG_LC 1
`define GPM_IEN_LC 1
`define GPM_CORE_GIE 7
`define GPM_EDGE_EI0 4
`define GPM_EDGE_EI1 5
`define GPM_FN_IR 0
`define GPM_FN_TIMER0_SOURCE_SELECT 1
`define GPM_FN_T0LCK 2
`define GPM_FN_TIMER1_SOURCE_SELECT 3
`define GPM_FN_TIMER2_SOURCE_SELECT 4
`define GPM_FN_TIMER3_SOURCE_SELECT 5
`define GPM_FN_COMPARATOR_PAD_ENABLE 6
`define GPM_FN_PWM1 7
`define GPM_FN_BZ1 8
`define GPM_FN_PWM2 9
`define GPM_FN_BZ2 10

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define GPM_RST_DIR 8'hff
`define GPM_RST_ZERO 8'h00
`define GPM_RST_FUNC 11'h000

`endif

// *** logic/gpm_pad_mux.v ***
// Purpose: GPIO unit for an 8-bit port A and 6-bit port B with pad function mux.
// Assumes: Pad inputs are synchronous to i_clk; Avalon-MM slave with waitrequest.
// Notes: Pulls and drives are reported as enables; the pad cell resolves the wire.
// Contract
// R01: Fourteen pins, eight on A, six on B, each port with data register.
// R02: Per-pin direction bits: A in bits 7:0, B in bits 5:0.
// R03: Pull resistors apply only to input pins with enable bit set; A5 configured as reset input gets pull-high without one.
// R04: Port A pull-high bits 7,6,4:0 enable pull-high on same pins.
// R05: A pull-high bit 5 and pull-low bits 3:0 enable A pull-lows.
// R06: Port B pull-high bits 5:0 enable pull-high on B pins.
// R07: Shared pull-low bits 7:4 enable pull-low on B pins 3:0.
// R08: Power control bit 4 enables pull-high on A pin 5.
// R09: Port B open-drain bits select open-drain drive on outputs.
// R10: Level-change flag sets on change at any wake-masked pin.
// R11: Level-change interrupt needs its enable and global enable.
// R12: Edge-control bits 4 and 5 make B0, B1 external interrupt inputs.
// R13: External interrupt disables level-change on B0 or B1 only.
// R14: IR carrier enable drives carrier on B1; otherwise no carrier.
// R15: Configured A5 acts as active-low external reset input.
// R16: Crystal mode turns A6 into crystal input, A7 output.
// R17: Internal oscillator with option drives instruction clock on A7.
// R18: A4 feeds timer0 (external, no low clock) and timer1 external clocks.
// R19: A1 feeds timers 2 and 3 when either picks external source.
// R20: B3 carries comparator, then PWM1, then buzzer1 output.
// R21: B2 carries PWM2 before buzzer2 output.
// R22: Level-change flag stays until software writes zero; sample compare.
// R23: Owning alternate function output replaces port data latch on pad.
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ns
`include "gpm_map.vh"

module gpm_pad_mux #(
    parameter PA_W = 8,
    parameter PB_W = 6
) (
    input wire i_clk, // System clock.
    input wire i_sys_rst, // Synchronous reset, high.
    input wire [`GPM_ADDR_W-1:0] i_avs_address, // Byte address.
    input wire i_avs_read, // Read request.
    input wire i_avs_write, // Write request.
    input wire [31:0] i_avs_writedata, // Write data.
    input wire [3:0] i_avs_byteenable, // Byte enables.
    output reg [31:0] o_avs_readdata, // Read data.
    output wire o_avs_waitrequest, // Stall request.
    input wire [PA_W-1:0] i_pa_pad, // Port A pad level.
    input wire [PB_W-1:0] i_pb_pad, // Port B pad level.
    output reg [PA_W-1:0] o_pa_out, // Port A drive value.
    output reg [PA_W-1:0] o_pa_oe, // Port A drive enable.
    output reg [PA_W-1:0] o_pa_pull_high, // Port A pull-high enable.
    output reg [PA_W-1:0] o_pa_pull_low, // Port A pull-low enable.
    output reg [PB_W-1:0] o_pb_out, // Port B drive value.
    output reg [PB_W-1:0] o_pb_oe, // Port B drive enable.
    output reg [PB_W-1:0] o_pb_pull_high, // Port B pull-high enable.
    output reg [PB_W-1:0] o_pb_pull_low, // Port B pull-low enable.
    input wire i_cfg_ext_reset, // Config: A5 is reset input.
    input wire i_cfg_crystal, // Config: external crystal used.
    input wire i_cfg_clk_out, // Config: instruction clock on A7.
    input wire i_inst_clk, // Instruction clock level.
    input wire i_xtal_out, // Crystal amplifier output.
    input wire i_ir_carrier, // IR carrier waveform.
    input wire i_cmp_out, // Comparator output.
    input wire i_pwm1, // PWM1 waveform.
    input wire i_bz1, // Buzzer1 waveform.
    input wire i_pwm2, // PWM2 waveform.
    input wire i_bz2, // Buzzer2 waveform.
    output wire o_ext_reset_n, // External reset, low active.
    output wire o_xtal_in, // Crystal input from A6.
    output wire o_tmr0_ext_clk, // Timer0 external clock.
    output wire o_tmr1_ext_clk, // Timer1 external clock.
    output wire o_tmr23_ext_clk, // Timer2/3 external clock.
    output wire o_ext_irq0, // External interrupt 0 level.
    output wire o_ext_irq1, // External interrupt 1 level.
    output wire o_lc_irq // Level-change interrupt request.
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg [PA_W-1:0] pa_data_q;
    reg [PB_W-1:0] pb_data_q;
    reg [PA_W-1:0] pa_dir_q;
    reg [PB_W-1:0] pb_dir_q;
    reg [7:0] pa_ph_q;
    reg [7:0] pl_q;
    reg [PB_W-1:0] pb_ph_q;
    reg [PB_W-1:0] pb_od_q;
    reg [PA_W-1:0] pa_wake_q;
    reg [PB_W-1:0] pb_wake_q;
    reg [7:0] pwr_q;
    reg lc_flag_q;
    reg lc_ien_q;
    reg gie_q;
    reg [7:0] edge_q;
    reg [10:0] func_q;
    reg [PA_W-1:0] pa_prev_q;
    reg [PB_W-1:0] pb_prev_q;
    reg rd_done_q;

    wire wr_lo = i_avs_write & i_avs_byteenable[0];
    wire wr_b1 = i_avs_write & i_avs_byteenable[1];
    wire ei0 = edge_q[`GPM_EDGE_EI0];
    wire ei1 = edge_q[`GPM_EDGE_EI1];

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    // Writes finish at once; reads take one wait cycle to register data.
    assign o_avs_waitrequest = i_avs_read & ~rd_done_q;

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            rd_done_q <= 1'b0;
        end else begin
            rd_done_q <= i_avs_read & ~rd_done_q;
        end
    end

    // ------------------------------------------------------------------
    // Level-change detection
    // ------------------------------------------------------------------
    reg [PB_W-1:0] pb_wake_eff;
    reg lc_hit;
    always @* begin
        pb_wake_eff = pb_wake_q;
        pb_wake_eff[0] = pb_wake_q[0] & ~ei0; // see R13
        pb_wake_eff[1] = pb_wake_q[1] & ~ei1; // see R13
        lc_hit = |((i_pa_pad ^ pa_prev_q) & pa_wake_q)
            | |((i_pb_pad ^ pb_prev_q) & pb_wake_eff); // see R10 see R22
    end

    assign o_lc_irq = lc_flag_q & lc_ien_q & gie_q; // see R11

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            pa_data_q <= {PA_W{1'b0}};
            pb_data_q <= {PB_W{1'b0}};
            pa_dir_q <= {PA_W{1'b1}};
            pb_dir_q <= {PB_W{1'b1}};
            pa_ph_q <= `GPM_RST_ZERO;
            pl_q <= `GPM_RST_ZERO;
            pb_ph_q <= {PB_W{1'b0}};
            pb_od_q <= {PB_W{1'b0}};
            pa_wake_q <= {PA_W{1'b0}};
            pb_wake_q <= {PB_W{1'b0}};
            pwr_q <= `GPM_RST_ZERO;
            lc_flag_q <= 1'b0;
            lc_ien_q <= 1'b0;
            gie_q <= 1'b0;
            edge_q <= `GPM_RST_ZERO;
            func_q <= `GPM_RST_FUNC;
            pa_prev_q <= {PA_W{1'b0}};
            pb_prev_q <= {PB_W{1'b0}};
        end else begin
            pa_prev_q <= i_pa_pad;
            pb_prev_q <= i_pb_pad;
            if (wr_lo) begin
                case (i_avs_address)
                    `GPM_OFF_PA_DATA: pa_data_q <= i_avs_writedata[PA_W-1:0]; // see R01
                    `GPM_OFF_PB_DATA: pb_data_q <= i_avs_writedata[PB_W-1:0]; // see R01
                    `GPM_OFF_PA_DIR: pa_dir_q <= i_avs_writedata[PA_W-1:0]; // see R02
                    `GPM_OFF_PB_DIR: pb_dir_q <= i_avs_writedata[PB_W-1:0]; // see R02
                    `GPM_OFF_PA_PH: pa_ph_q <= i_avs_writedata[7:0];
                    `GPM_OFF_PL: pl_q <= i_avs_writedata[7:0];
                    `GPM_OFF_PB_PH: pb_ph_q <= i_avs_writedata[PB_W-1:0];
                    `GPM_OFF_PB_OD: pb_od_q <= i_avs_writedata[PB_W-1:0];
                    `GPM_OFF_PA_WAKE: pa_wake_q <= i_avs_writedata[PA_W-1:0];
                    `GPM_OFF_PB_WAKE: pb_wake_q <= i_avs_writedata[PB_W-1:0];
                    `GPM_OFF_PWR: pwr_q <= i_avs_writedata[7:0];
                    `GPM_OFF_IEN: lc_ien_q <= i_avs_writedata[`GPM_IEN_LC];
                    `GPM_OFF_CORE: gie_q <= i_avs_writedata[`GPM_CORE_GIE];
                    `GPM_OFF_EDGE: edge_q <= i_avs_writedata[7:0];
                    `GPM_OFF_FUNC: func_q[7:0] <= i_avs_writedata[7:0];
                    default: ;
                endcase
            end
            if (wr_b1 && i_avs_address == `GPM_OFF_FUNC) begin
                func_q[10:8] <= i_avs_writedata[10:8];
            end
            // A new change wins over a software clear in the same cycle.
            if (lc_hit) begin
                lc_flag_q <= 1'b1; // see R10
            end else if (wr_lo && i_avs_address == `GPM_OFF_IFLAG
                    && !i_avs_writedata[`GPM_IFLAG_LC]) begin
                lc_flag_q <= 1'b0; // see R22
            end
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        case (i_avs_address)
            `GPM_OFF_PA_DATA: rd_mux[PA_W-1:0] = (pa_dir_q & i_pa_pad) | (~pa_dir_q & pa_data_q);
            `GPM_OFF_PB_DATA: rd_mux[PB_W-1:0] = (pb_dir_q & i_pb_pad) | (~pb_dir_q & pb_data_q);
            `GPM_OFF_PA_DIR: rd_mux[PA_W-1:0] = pa_dir_q;
            `GPM_OFF_PB_DIR: rd_mux[PB_W-1:0] = pb_dir_q;
            `GPM_OFF_PA_PH: rd_mux[7:0] = pa_ph_q;
            `GPM_OFF_PL: rd_mux[7:0] = pl_q;
            `GPM_OFF_PB_PH: rd_mux[PB_W-1:0] = pb_ph_q;
            `GPM_OFF_PB_OD: rd_mux[PB_W-1:0] = pb_od_q;
            `GPM_OFF_PA_WAKE: rd_mux[PA_W-1:0] = pa_wake_q;
            `GPM_OFF_PB_WAKE: rd_mux[PB_W-1:0] = pb_wake_q;
            `GPM_OFF_PWR: rd_mux[7:0] = pwr_q;
            `GPM_OFF_IFLAG: rd_mux[`GPM_IFLAG_LC] = lc_flag_q;
            `GPM_OFF_IEN: rd_mux[`GPM_IEN_LC] = lc_ien_q;
            `GPM_OFF_CORE: rd_mux[`GPM_CORE_GIE] = gie_q;
            `GPM_OFF_EDGE: rd_mux[7:0] = edge_q;
            `GPM_OFF_FUNC: rd_mux[10:0] = func_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_avs_read && !rd_done_q) begin
            o_avs_readdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // Pad drive and pulls
    // ------------------------------------------------------------------
    wire a5_reset = i_cfg_ext_reset;
    wire a7_clk = ~i_cfg_crystal & i_cfg_clk_out;
    wire b3_cmp = func_q[`GPM_FN_COMPARATOR_PAD_ENABLE];
    wire b3_pwm = func_q[`GPM_FN_PWM1];
    wire b3_bz = func_q[`GPM_FN_BZ1];
    wire b2_pwm = func_q[`GPM_FN_PWM2];
    wire b2_bz = func_q[`GPM_FN_BZ2];
    wire b1_ir = func_q[`GPM_FN_IR];

    reg [PA_W-1:0] pa_out_d;
    reg [PA_W-1:0] pa_oe_d;
    reg [PA_W-1:0] pa_ph_d;
    reg [PA_W-1:0] pa_pl_d;
    reg [PB_W-1:0] pb_out_d;
    reg [PB_W-1:0] pb_oe_d;
    reg [PB_W-1:0] pb_drv;
    always @* begin
        pa_out_d = pa_data_q;
        pa_oe_d = ~pa_dir_q; // see R02
        // Pulls only on pins set as inputs.
        pa_ph_d = pa_dir_q & {pa_ph_q[7:6], pwr_q[`GPM_PWR_PA5_PH], pa_ph_q[4:0]}; // see R03 R04 R08
        pa_pl_d = pa_dir_q & {2'b00, pa_ph_q[5], 1'b0, pl_q[3:0]}; // see R05
        if (a5_reset) begin
            pa_oe_d[5] = 1'b0; // see R15
            pa_ph_d[5] = 1'b1;
            pa_pl_d[5] = 1'b0;
        end
        if (i_cfg_crystal) begin
            pa_oe_d[6] = 1'b0; // see R16
            pa_out_d[7] = i_xtal_out;
            pa_oe_d[7] = 1'b1;
            pa_ph_d[7:6] = 2'b00;
            pa_pl_d[7:6] = 2'b00;
        end else if (a7_clk) begin
            pa_out_d[7] = i_inst_clk; // see R17
            pa_oe_d[7] = 1'b1;
            pa_ph_d[7] = 1'b0;
        end
        pb_out_d = pb_data_q;
        pb_drv = ~pb_dir_q;
        if (b1_ir) begin
            pb_out_d[1] = i_ir_carrier; // see R14
            pb_drv[1] = 1'b1;
        end
        if (b2_pwm) begin
            pb_out_d[2] = i_pwm2; // see R21 R23
            pb_drv[2] = 1'b1;
        end else if (b2_bz) begin
            pb_out_d[2] = i_bz2; // see R21
            pb_drv[2] = 1'b1;
        end
        if (b3_cmp) begin
            pb_out_d[3] = i_cmp_out; // see R20 R23
            pb_drv[3] = 1'b1;
        end else if (b3_pwm) begin
            pb_out_d[3] = i_pwm1; // see R20
            pb_drv[3] = 1'b1;
        end else if (b3_bz) begin
            pb_out_d[3] = i_bz1; // see R20
            pb_drv[3] = 1'b1;
        end
        // Open-drain pins drive only the low level.
        pb_oe_d = pb_drv & ~(pb_od_q & pb_out_d); // see R09
    end

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_pa_out <= {PA_W{1'b0}};
            o_pa_oe <= {PA_W{1'b0}};
            o_pa_pull_high <= {PA_W{1'b0}};
            o_pa_pull_low <= {PA_W{1'b0}};
            o_pb_out <= {PB_W{1'b0}};
            o_pb_oe <= {PB_W{1'b0}};
            o_pb_pull_high <= {PB_W{1'b0}};
            o_pb_pull_low <= {PB_W{1'b0}};
        end else begin
            o_pa_out <= pa_out_d;
            o_pa_oe <= pa_oe_d;
            o_pa_pull_high <= pa_ph_d;
            o_pa_pull_low <= pa_pl_d;
            o_pb_out <= pb_out_d;
            o_pb_oe <= pb_oe_d;
            o_pb_pull_high <= pb_dir_q & ~pb_drv & pb_ph_q; // see R03 R06
            o_pb_pull_low <= pb_dir_q & ~pb_drv & {2'b00, pl_q[7:4]}; // see R07
        end
    end

    // ------------------------------------------------------------------
    // Alternate inputs
    // ------------------------------------------------------------------
    assign o_ext_reset_n = a5_reset ? i_pa_pad[5] : 1'b1; // see R15
    assign o_xtal_in = i_cfg_crystal & i_pa_pad[6]; // see R16
    assign o_tmr0_ext_clk = func_q[`GPM_FN_TIMER0_SOURCE_SELECT] & ~func_q[`GPM_FN_T0LCK]
        & i_pa_pad[4]; // see R18
    assign o_tmr1_ext_clk = func_q[`GPM_FN_TIMER1_SOURCE_SELECT] & i_pa_pad[4]; // see R18
    assign o_tmr23_ext_clk = (func_q[`GPM_FN_TIMER2_SOURCE_SELECT] | func_q[`GPM_FN_TIMER3_SOURCE_SELECT])
        & i_pa_pad[1]; // see R19
    assign o_ext_irq0 = ei0 & i_pb_pad[0]; // see R12
    assign o_ext_irq1 = ei1 & i_pb_pad[1]; // see R12

endmodule // gpm_pad_mux

// *** test/gpm_pad_model.sv ***
// Purpose: Board-side model of the port A or port B pads.
// Assumes: Block drive beats board drive, board drive beats pulls.
// Notes: An undriven, unpulled pad flips every cycle so that no stale level survives.
`timescale 1ns/1ns
module gpm_pad_model #(
    parameter int W = 8
) (
    input wire logic i_clk, // Clock.
    input wire logic [W-1:0] i_out, // Block drive value.
    input wire logic [W-1:0] i_oe, // Block drive enable.
    input wire logic [W-1:0] i_ph, // Pull-high enable.
    input wire logic [W-1:0] i_pl, // Pull-low enable.
    input wire logic [W-1:0] i_ext_en, // Board drive enable.
    input wire logic [W-1:0] i_ext_val, // Board drive value.
    output logic [W-1:0] o_pad // Resolved pad level.
);
    logic [W-1:0] float_q = '0;
    always_ff @(posedge i_clk) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int k = 0; k < W; k++) begin
            if (i_oe[k] === 1'b1) o_pad[k] = i_out[k];
            else if (i_ext_en[k]) o_pad[k] = i_ext_val[k];
            else if (i_ph[k] === 1'b1) o_pad[k] = 1'b1;
            else if (i_pl[k] === 1'b1) o_pad[k] = 1'b0;
            else o_pad[k] = float_q[k];
        end
    end
endmodule // gpm_pad_model

// *** test/gpm_pad_mux_asserts.sv ***
// Purpose: Port-level checks of the GPIO pad block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Attached to every instance of the block by bind.
`timescale 1ns/1ns
module gpm_pad_mux_chk #(
    parameter PA_W = 8,
    parameter PB_W = 6
) (
    input wire i_clk, // Clock.
    input wire i_sys_rst, // Reset.
    input wire i_avs_read, // Read request.
    input wire i_avs_write, // Write request.
    input wire o_avs_waitrequest, // Stall.
    input wire [PA_W-1:0] i_pa_pad, // Port A pads.
    input wire [PB_W-1:0] i_pb_pad, // Port B pads.
    input wire [PA_W-1:0] o_pa_out, // Port A drive.
    input wire [PA_W-1:0] o_pa_oe, // Port A enable.
    input wire [PA_W-1:0] o_pa_pull_high, // Port A pull-high.
    input wire [PA_W-1:0] o_pa_pull_low, // Port A pull-low.
    input wire [PB_W-1:0] o_pb_oe, // Port B enable.
    input wire [PB_W-1:0] o_pb_pull_high, // Port B pull-high.
    input wire [PB_W-1:0] o_pb_pull_low, // Port B pull-low.
    input wire i_cfg_ext_reset, // Reset pin option.
    input wire i_cfg_crystal, // Crystal option.
    input wire i_cfg_clk_out, // Clock-out option.
    input wire i_inst_clk, // Instruction clock.
    input wire o_ext_reset_n, // External reset.
    input wire o_xtal_in, // Crystal input.
    input wire o_ext_irq0, // External interrupt 0.
    input wire o_ext_irq1, // External interrupt 1.
    input wire o_lc_irq // Level-change request.
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    wr_no_wait_a: assert property (i_avs_write |-> !o_avs_waitrequest)
        else $error("write was stalled");
    rd_one_wait_a: assert property ($rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("read wait is not one cycle");
    ext_reset_a: assert property (o_ext_reset_n == (i_cfg_ext_reset ? i_pa_pad[5] : 1'b1))
        else $error("external reset does not follow pin 5");
    xtal_in_a: assert property (i_cfg_crystal |-> o_xtal_in == i_pa_pad[6])
        else $error("crystal input does not follow pin 6");
    xtal_pad_a: assert property (i_cfg_crystal [*2] |-> !o_pa_oe[6])
        else $error("crystal input pin is driven");
    clk_out_a: assert property ((!i_cfg_crystal && i_cfg_clk_out) [*2]
        |-> o_pa_oe[7] && o_pa_out[7] == $past(i_inst_clk))
        else $error("instruction clock missing on pin 7");
    irq_gate_a: assert property ((!o_ext_irq0 || i_pb_pad[0]) && (!o_ext_irq1 || i_pb_pad[1]))
        else $error("external interrupt without its pin");
    lc_clear_a: assert property ($fell(o_lc_irq) |-> $past(i_avs_write))
        else $error("level-change request fell without a write");
    pull_input_a: assert property ((((o_pa_pull_high | o_pa_pull_low) & o_pa_oe) == '0)
        && (((o_pb_pull_high | o_pb_pull_low) & o_pb_oe) == '0))
        else $error("pull enabled on a driven pin");
    pull_low_fixed_a: assert property (o_pa_pull_low[7:6] == 2'b00 && !o_pa_pull_low[4]
        && o_pb_pull_low[5:4] == 2'b00)
        else $error("pull-low on a pin without one");
endmodule // gpm_pad_mux_chk
bind gpm_pad_mux gpm_pad_mux_chk #(.PA_W(PA_W), .PB_W(PB_W)) chk_u (.*);

// *** test/tb_top.sv ***
// Purpose: Self-checking bench of the GPIO pad block.
// Assumes: Avalon-MM master waits for waitrequest low before releasing.
// Notes: Function waveforms are run at a value and its inverse.
`timescale 1ns/1ns
`include "gpm_map.vh"
module tb_top;
    logic i_clk = 1'b0, i_sys_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
    logic [5:0] i_avs_address = 6'h00;
    logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata;
    logic [3:0] i_avs_byteenable = 4'hf;
    logic o_avs_waitrequest, o_ext_reset_n, o_xtal_in, o_tmr0_ext_clk, o_tmr1_ext_clk;
    logic o_tmr23_ext_clk, o_ext_irq0, o_ext_irq1, o_lc_irq;
    logic [7:0] i_pa_pad, o_pa_out, o_pa_oe, o_pa_pull_high, o_pa_pull_low;
    logic [5:0] i_pb_pad, o_pb_out, o_pb_oe, o_pb_pull_high, o_pb_pull_low;
    logic [7:0] pa_en = 8'h00, pa_val = 8'h00, wave = 8'hb5;
    logic [5:0] pb_en = 6'h00, pb_val = 6'h00;
    logic i_cfg_ext_reset = 1'b0, i_cfg_crystal = 1'b0, i_cfg_clk_out = 1'b0;
    wire i_inst_clk, i_xtal_out, i_ir_carrier, i_cmp_out, i_pwm1, i_bz1, i_pwm2, i_bz2;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [10:0] fn [12] = '{11'h000, 11'h1c0, 11'h180, 11'h100, 11'h600, 11'h400,
        11'h001, 11'h002, 11'h006, 11'h008, 11'h010, 11'h020};
    logic [8:0] ex [12] = '{9'h000, 9'h120, 9'h100, 9'h120, 9'h080, 9'h090,
        9'h048, 9'h004, 9'h000, 9'h002, 9'h001, 9'h001};
    assign {i_inst_clk, i_xtal_out, i_ir_carrier, i_cmp_out, i_pwm1, i_bz1, i_pwm2, i_bz2} = wave;
    gpm_pad_mux dut_u (.*);
    gpm_pad_model #(.W(8)) pad_a_u (.i_clk(i_clk), .i_out(o_pa_out), .i_oe(o_pa_oe),
        .i_ph(o_pa_pull_high), .i_pl(o_pa_pull_low), .i_ext_en(pa_en), .i_ext_val(pa_val),
        .o_pad(i_pa_pad));
    gpm_pad_model #(.W(6)) pad_b_u (.i_clk(i_clk), .i_out(o_pb_out), .i_oe(o_pb_oe),
        .i_ph(o_pb_pull_high), .i_pl(o_pb_pull_low), .i_ext_en(pb_en), .i_ext_val(pb_val),
        .o_pad(i_pb_pad));
    initial forever #5 i_clk = ~i_clk;
    task automatic report_and_stop;
        if (errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            $display("Error %0t: timeout", $time);
            report_and_stop;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_byteenable <= be;
        i_avs_write <= 1'b1;
        do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
        i_avs_write <= 1'b0;
    endtask
    task automatic rdc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_read <= 1'b1;
        do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
        i_avs_read <= 1'b0;
        chk(o_avs_readdata & m, e);
    endtask
    task automatic settle;
        repeat (3) @(posedge i_clk);
        #1;
    endtask
    task automatic pads(input logic [7:0] ae, av, input logic [5:0] be, bv);
        @(posedge i_clk);
        pa_en <= ae;
        pa_val <= av;
        pb_en <= be;
        pb_val <= bv;
    endtask
    task automatic t_reset;
        settle;
        chk(o_pa_oe, 8'h00);
        chk(o_pb_oe, 6'h00);
        rdc(`GPM_OFF_PA_DIR, 32'hff, 32'hff);
        rdc(`GPM_OFF_PB_DIR, 32'h3f, 32'h3f);
    endtask
    task automatic t_data;
        pads(8'h0f, 8'h03, 6'h00, 6'h00);
        wr(`GPM_OFF_PA_DIR, 32'h0f);
        wr(`GPM_OFF_PA_DATA, 32'ha5);
        wr(`GPM_OFF_PB_DIR, 32'h00);
        wr(`GPM_OFF_PB_DATA, 32'h15);
        settle;
        chk(o_pa_oe, 8'hf0);
        chk(o_pa_out & 8'hf0, 8'ha0);
        chk(o_pb_out, 6'h15);
        rdc(`GPM_OFF_PA_DATA, 32'hff, 32'ha3);
        rdc(`GPM_OFF_PB_DATA, 32'h3f, 32'h15);
    endtask
    task automatic t_pulls;
        wr(`GPM_OFF_PA_DIR, 32'hff);
        wr(`GPM_OFF_PB_DIR, 32'h3f);
        pads(8'h00, 8'h00, 6'h00, 6'h00);
        wr(`GPM_OFF_PA_PH, 32'hff);
        wr(`GPM_OFF_PL, 32'hff);
        wr(`GPM_OFF_PWR, 32'h10);
        wr(`GPM_OFF_PB_PH, 32'h3f);
        settle;
        chk(o_pa_pull_high, 8'hff);
        chk(o_pa_pull_low, 8'h2f);
        chk(o_pb_pull_high, 6'h3f);
        chk(o_pb_pull_low, 6'h0f);
        wr(`GPM_OFF_PA_PH, 32'h20);
        wr(`GPM_OFF_PL, 32'h50);
        wr(`GPM_OFF_PWR, 32'h00);
        wr(`GPM_OFF_PB_PH, 32'h00);
        settle;
        chk(o_pa_pull_high, 8'h00);
        chk(o_pa_pull_low, 8'h20);
        chk(o_pb_pull_low, 6'h05);
        wr(`GPM_OFF_PA_DIR, 32'h00);
        wr(`GPM_OFF_PB_DIR, 32'h00);
        settle;
        chk({o_pa_pull_low, o_pb_pull_low}, 14'h0000);
    endtask
    task automatic t_od;
        wr(`GPM_OFF_PB_OD, 32'h0f);
        wr(`GPM_OFF_PB_DATA, 32'h05);
        settle;
        chk(o_pb_oe, 6'h3a);
        chk(o_pb_out & o_pb_oe, 6'h00);
        wr(`GPM_OFF_PB_OD, 32'h00);
        settle;
        chk(o_pb_oe, 6'h3f);
    endtask
    task automatic t_lc;
        wr(`GPM_OFF_PA_DIR, 32'hff);
        wr(`GPM_OFF_PB_DIR, 32'h3f);
        pads(8'hff, 8'h00, 6'h3f, 6'h00);
        wr(`GPM_OFF_PA_WAKE, 32'h01);
        wr(`GPM_OFF_PB_WAKE, 32'h05);
        wr(`GPM_OFF_EDGE, 32'h30);
        wr(`GPM_OFF_IEN, 32'h02);
        wr(`GPM_OFF_CORE, 32'h80);
        wr(`GPM_OFF_IFLAG, 32'h00);
        pads(8'hff, 8'h02, 6'h3f, 6'h03);
        settle;
        rdc(`GPM_OFF_IFLAG, 32'h02, 32'h00);
        chk({o_ext_irq0, o_ext_irq1, o_lc_irq}, 3'b110);
        pads(8'hff, 8'h03, 6'h3f, 6'h03);
        settle;
        rdc(`GPM_OFF_IFLAG, 32'h02, 32'h02);
        chk(o_lc_irq, 1'b1);
        wr(`GPM_OFF_CORE, 32'h00);
        settle;
        chk(o_lc_irq, 1'b0);
        wr(`GPM_OFF_CORE, 32'h80);
        wr(`GPM_OFF_IEN, 32'h00);
        settle;
        chk(o_lc_irq, 1'b0);
        rdc(`GPM_OFF_IFLAG, 32'h02, 32'h02);
        wr(`GPM_OFF_IFLAG, 32'h00);
        rdc(`GPM_OFF_IFLAG, 32'h02, 32'h00);
        pads(8'hff, 8'h03, 6'h3f, 6'h07);
        settle;
        rdc(`GPM_OFF_IFLAG, 32'h02, 32'h02);
    endtask
    task automatic t_func;
        wr(`GPM_OFF_PB_DIR, 32'h00);
        wr(`GPM_OFF_PB_DATA, 32'h00);
        pads(8'hff, 8'h12, 6'h00, 6'h00);
        for (int k = 0; k < 12; k++) begin
            wr(`GPM_OFF_FUNC, {21'h0, fn[k]}, 4'h3);
            for (int p = 0; p < 2; p++) begin
                @(posedge i_clk);
                wave <= (p == 1) ? 8'h4a : 8'hb5;
                settle;
                chk({o_pb_out[3:1], o_tmr0_ext_clk, o_tmr1_ext_clk, o_tmr23_ext_clk},
                    ex[k][5:0] ^ ((p == 1) ? {ex[k][8:6], 3'b000} : 6'h00));
            end
        end
        wr(`GPM_OFF_FUNC, 32'h0001, 4'h2);
        settle;
        chk({o_pb_out[1], o_tmr23_ext_clk}, 2'b01);
    endtask
    task automatic t_cfg;
        wr(`GPM_OFF_PA_DIR, 32'h00);
        wr(`GPM_OFF_PA_DATA, 32'h00);
        @(posedge i_clk);
        i_cfg_ext_reset <= 1'b1;
        pads(8'h20, 8'h00, 6'h00, 6'h00);
        settle;
        chk({o_ext_reset_n, o_pa_oe[5]}, 2'b00);
        pads(8'h20, 8'h20, 6'h00, 6'h00);
        settle;
        chk(o_ext_reset_n, 1'b1);
        @(posedge i_clk);
        i_cfg_ext_reset <= 1'b0;
        i_cfg_crystal <= 1'b1;
        i_cfg_clk_out <= 1'b1;
        pads(8'h40, 8'h40, 6'h00, 6'h00);
        settle;
        chk({o_xtal_in, o_pa_oe[6]}, 2'b10);
        @(posedge i_clk);
        i_cfg_crystal <= 1'b0;
        settle;
        chk({o_pa_oe[7], o_pa_out[7]}, {1'b1, wave[7]});
        @(posedge i_clk);
        i_cfg_clk_out <= 1'b0;
        settle;
        chk(o_pa_out[7], 1'b0);
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        t_reset;
        t_data;
        t_pulls;
        t_od;
        t_lc;
        t_func;
        t_cfg;
        report_and_stop;
    end
endmodule // tb_top
